/* File: pkg/dgfd_regs.vh */
`ifndef DGFD_REGS_VH
`define DGFD_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DGFD_CTRL_OFS 8'h00
`define DGFD_ULMASK_OFS 8'h04
`define DGFD_WORDLO_OFS 8'h08
`define DGFD_WORDHI_OFS 8'h0C
`define DGFD_DECODE_OFS 8'h10
`define DGFD_RESA_OFS 8'h14
`define DGFD_RESB_OFS 8'h18
`define DGFD_RESRA_OFS 8'h1C
`define DGFD_SCHED_OFS 8'h20

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define DGFD_CTRL_CFG_LSB 0
`define DGFD_CTRL_PORTS4_BIT 2
`define DGFD_CTRL_WINCLR_BIT 3
`define DGFD_CTRL_FMT_LSB 4
`define DGFD_CTRL_SLOT_LSB 8
`define DGFD_CTRL_RST 32'h0000_0000
`define DGFD_ULMASK_RST 10'h000

// ----------------------------------------------------------------
// format selector codes
// ----------------------------------------------------------------
`define DGFD_FMT_0_1A 3'h0
`define DGFD_FMT_1 3'h1
`define DGFD_FMT_1B 3'h2
`define DGFD_FMT_1C 3'h3
`define DGFD_FMT_1D 3'h4
`define DGFD_FMT_2 3'h5
`define DGFD_FMT_1A_OUT 3'h6

// ----------------------------------------------------------------
// field widths and fixed positions
// ----------------------------------------------------------------
`define DGFD_MCS_W 5
`define DGFD_HARQ_W 4
`define DGFD_RV_W 2
`define DGFD_TPC_W 2
`define DGFD_DAI_W 2
`define DGFD_ACCESS_W 6
`define DGFD_MASK_W 4
`define DGFD_TBS_W 5
`define DGFD_F0_ULSEL_LSB 1
`define DGFD_F0_DAI_LSB 3
`define DGFD_F0_CQI_BIT 5
`define DGFD_TAIL_LEN 16

// ----------------------------------------------------------------
// uplink slot select codes and timing
// ----------------------------------------------------------------
`define DGFD_ULSEL_RSVD 2'h0
`define DGFD_ULSEL_SECOND 2'h1
`define DGFD_ULSEL_FIRST 2'h2
`define DGFD_ULSEL_BOTH 2'h3
`define DGFD_MIN_X 4
`define DGFD_SLOTS 10
`define DGFD_DECODE_CYCLES 1

`endif

/* File: hdl/dgfd_decoder.v */
// Notes on behaviour
// - uplink slot select 10 first, 01 second, 11 both, 00 reserved.
// - scheduled uplink slots are n+x, x first/second valid uplink offset from 4.
// - uplink grant assignment index code 00..11 gives value 1..4.
// - quality request bit set asks for an aperiodic quality/precoder/rank report.
// - offset k per slot: config 0 and 1 table entries of 4 and 6.
// - config 2 k=4, config 3 k=7 or 5; config 0 may use 7.
// - allocation header clear selects type 0, set selects type 1.
// - modulation and coding field is 5 bits.
// - retransmission process number is 4 bits.
// - redundancy version is 2 bits, codes map to versions 0..3.
// - control channel power command maps to -1, 0, +1, +3 dB.
// - downlink assignment index is a running count; gaps reveal missed grants.
// - virtual resource flag 0 localized, 1 distributed.
// - granted precoder index is 2 bits with 2 ports, 4 with 4.
// - confirmation bit picks reported precoder or the granted index.
// - compact broadcast grant carries gap bit, type 2 assignment, 5-bit size index.
// - power offset bit 0 means -10log10(2) dB, 1 means 0 dB.
// - single-antenna bitmap grant field order is fixed.
// - compact grant adds 6-bit access sequence and 4-bit mask index.
// - closed-loop single-rank grant ends with precoder index and confirmation.
// - multi-user grant replaces confirmation with the power offset bit.
// - multi-layer grant begins header, assignment, power, index, process number.
// - format flag 0 is uplink grant, 1 is compact downlink grant.
// - new-data toggle flips per new block, holds on retransmission.
`timescale 1ns/1ps
`include "dgfd_regs.vh"

module dgfd_decoder #(
  parameter RA_W = 13
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_reset,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // decoded grant
  output reg o_grant_valid,
  output reg [2:0] o_format,
  output reg o_bad_grant,
  output reg [RA_W-1:0] o_resource_assignment,
  output reg o_alloc_type1,
  output reg o_distributed,
  output reg o_gap,
  output reg [4:0] o_mcs,
  output reg [3:0] o_harq,
  output reg o_new_block,
  output reg [1:0] o_rv,
  output reg [2:0] o_ctrl_power_step,
  output reg [2:0] o_assign_value,
  output reg [1:0] o_missed_grants,
  output reg o_report_request,
  output reg [3:0] o_granted_precoder_index,
  output reg o_use_granted_precoder,
  output reg o_power_offset_low,
  output reg [5:0] o_access_seq,
  output reg [3:0] o_mask_index,
  output reg [4:0] o_tbs_index,
  // uplink scheduling
  output reg o_ul_first_valid,
  output reg [3:0] o_ul_first_slot,
  output reg o_ul_second_valid,
  output reg [3:0] o_ul_second_slot,
  output reg [2:0] o_k_offset,
  output reg o_sched_valid,
  output reg [3:0] o_sched_slot
);

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam F1_TAIL = 1 + RA_W;
  localparam F1A_RA = 2;
  localparam F1A_TAIL = 2 + RA_W;
  localparam F1A_ACC = F1A_TAIL + `DGFD_TAIL_LEN;
  localparam F1A_MASK = F1A_ACC + `DGFD_ACCESS_W;
  localparam FB_TAIL = 1 + RA_W;
  localparam FB_GRANTED_PRECODER_INDEX = FB_TAIL + `DGFD_TAIL_LEN;
  localparam F2_TPC = 1 + RA_W;
  localparam F2_DAI = F2_TPC + `DGFD_TPC_W;
  localparam F2_HARQ = F2_DAI + `DGFD_DAI_W;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl;
  reg [9:0] ul_mask;
  reg [63:0] grant_word;
  reg decode_go;
  reg [1:0] last_dai;
  reg [15:0] ndi_seen;
  reg [15:0] harq_used;
  wire wb_req;
  wire wb_wr;

  assign wb_req = i_wb_cyc & i_wb_stb;
  assign wb_wr = wb_req & i_wb_we & o_wb_ack;

  wire [1:0] ul_cfg = ctrl[`DGFD_CTRL_CFG_LSB +: 2];
  wire four_ports = ctrl[`DGFD_CTRL_PORTS4_BIT];
  wire [2:0] fmt_sel = ctrl[`DGFD_CTRL_FMT_LSB +: 3];
  wire [3:0] slot_n = ctrl[`DGFD_CTRL_SLOT_LSB +: 4];

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // offset x of the first or second uplink slot at n+x, x from 4; zero if none
  function [4:0] ul_search;
    input [9:0] mask;
    input [3:0] n;
    input second;
    integer i;
    reg [4:0] s;
    reg [1:0] hits;
    reg [4:0] res;
    begin
      hits = 2'h0;
      res = 5'h00;
      for (i = `DGFD_MIN_X; i < `DGFD_MIN_X + `DGFD_SLOTS; i = i + 1)
      begin
        s = {1'b0, n} + i[4:0];
        if (s >= `DGFD_SLOTS)
          s = s - 5'h0A;
        if (mask[s[3:0]] && res == 5'h00)
        begin
          if (hits == {1'b0, second})
            res = i[4:0];
          hits = hits + 2'h1;
        end
      end
      ul_search = res;
    end
  endfunction

  // offset k for an uplink grant in slot n; zero when slot carries none
  function [2:0] k_lookup;
    input [1:0] cfg;
    input [3:0] n;
    input late;
    begin
      k_lookup = 3'h0;
      case (cfg)
        2'h0:
        begin
          if (n == 4'h0 || n == 4'h5)
            k_lookup = late ? 3'h7 : 3'h4;
          else if (n == 4'h1 || n == 4'h6)
            k_lookup = late ? 3'h7 : 3'h6;
        end
        2'h1:
        begin
          if (n == 4'h1 || n == 4'h6)
            k_lookup = 3'h6;
          else if (n == 4'h4 || n == 4'h9)
            k_lookup = 3'h4;
        end
        2'h2:
        begin
          if (n == 4'h3 || n == 4'h8)
            k_lookup = 3'h4;
        end
        default:
        begin
          if (n == 4'h0 || n == 4'h1 || n == 4'h5 || n == 4'h6)
            k_lookup = 3'h7;
          else if (n == 4'h9)
            k_lookup = 3'h5;
        end
      endcase
    end
  endfunction

  function [3:0] slot_add;
    input [3:0] n;
    input [4:0] x;
    reg [5:0] s;
    begin
      s = {2'h0, n} + {1'b0, x};
      if (s >= 6'd20)
        s = s - 6'd20;
      else if (s >= 6'd10)
        s = s - 6'd10;
      slot_add = s[3:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave: one wait state, ack pulses for one cycle
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_wb_ack <= 1'b0;
      ctrl <= `DGFD_CTRL_RST;
      ul_mask <= `DGFD_ULMASK_RST;
      grant_word <= 64'h0000_0000_0000_0000;
      decode_go <= 1'b0;
    end
    else
    begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      decode_go <= 1'b0;
      if (wb_wr)
      begin
        case (i_wb_adr)
          `DGFD_CTRL_OFS:
          begin
            if (i_wb_sel[0])
              ctrl[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1])
              ctrl[15:8] <= i_wb_dat[15:8];
          end
          `DGFD_ULMASK_OFS:
          begin
            if (i_wb_sel[0])
              ul_mask[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1])
              ul_mask[9:8] <= i_wb_dat[9:8];
          end
          `DGFD_WORDLO_OFS:
            grant_word[31:0] <= i_wb_dat;
          `DGFD_WORDHI_OFS:
            grant_word[63:32] <= i_wb_dat;
          `DGFD_DECODE_OFS:
            decode_go <= 1'b1;
          default:
            decode_go <= 1'b0;
        endcase
      end
      if (ctrl[`DGFD_CTRL_WINCLR_BIT])
        ctrl[`DGFD_CTRL_WINCLR_BIT] <= 1'b0;
    end
  end

  always @*
  begin
    case (i_wb_adr)
      `DGFD_CTRL_OFS:
        o_wb_dat = {16'h0000, ctrl[15:0]};
      `DGFD_ULMASK_OFS:
        o_wb_dat = {22'h000000, ul_mask};
      `DGFD_WORDLO_OFS:
        o_wb_dat = grant_word[31:0];
      `DGFD_WORDHI_OFS:
        o_wb_dat = grant_word[63:32];
      `DGFD_RESA_OFS:
        o_wb_dat = {2'h0, o_gap, o_distributed, o_alloc_type1, o_power_offset_low,
          o_use_granted_precoder, o_report_request, o_missed_grants, o_assign_value,
          o_ctrl_power_step, o_rv, o_harq, o_mcs, o_new_block, o_bad_grant, o_format};
      `DGFD_RESB_OFS:
        o_wb_dat = {o_k_offset, o_ul_second_valid, o_ul_second_slot, o_ul_first_valid,
          o_ul_first_slot, o_tbs_index, o_mask_index, o_access_seq,
          o_granted_precoder_index};
      `DGFD_RESRA_OFS:
        o_wb_dat = {{(32 - RA_W){1'b0}}, o_resource_assignment};
      `DGFD_SCHED_OFS:
        o_wb_dat = {27'h0000000, o_sched_valid, o_sched_slot};
      default:
        o_wb_dat = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  reg [2:0] next_format;
  reg next_bad;
  reg is_dl;
  reg [RA_W-1:0] next_ra;
  reg next_type1;
  reg next_dist;
  reg next_gap;
  reg [4:0] next_mcs;
  reg [3:0] next_harq;
  reg next_ndi;
  reg [1:0] next_rv;
  reg [1:0] next_tpc;
  reg [1:0] next_dai;
  reg [1:0] next_ulsel;
  reg next_cqi;
  reg [3:0] next_granted_precoder_index;
  reg next_confirm;
  reg next_offset_bit;
  reg [5:0] next_access;
  reg [3:0] next_mask;
  reg [4:0] next_tbs;
  reg [4:0] tail;

  always @*
  begin
    next_format = fmt_sel;
    next_bad = 1'b0;
    is_dl = 1'b1;
    next_ra = {RA_W{1'b0}};
    next_type1 = 1'b0;
    next_dist = 1'b0;
    next_gap = 1'b0;
    next_mcs = 5'h00;
    next_harq = 4'h0;
    next_ndi = 1'b0;
    next_rv = 2'h0;
    next_tpc = 2'h0;
    next_dai = 2'h0;
    next_ulsel = 2'h0;
    next_cqi = 1'b0;
    next_granted_precoder_index = 4'h0;
    next_confirm = 1'b0;
    next_offset_bit = 1'b0;
    next_access = 6'h00;
    next_mask = 4'h0;
    next_tbs = 5'h00;
    tail = 5'h00;
    case (fmt_sel)
      `DGFD_FMT_0_1A:
      begin
        if (!grant_word[0])
        begin
          is_dl = 1'b0;
          next_ulsel = grant_word[`DGFD_F0_ULSEL_LSB +: 2];
          next_dai = grant_word[`DGFD_F0_DAI_LSB +: 2];
          next_cqi = grant_word[`DGFD_F0_CQI_BIT];
          next_bad = (next_ulsel == `DGFD_ULSEL_RSVD);
        end
        else
        begin
          next_format = `DGFD_FMT_1A_OUT;
          next_dist = grant_word[1];
          next_ra = grant_word[F1A_RA +: RA_W];
          {next_dai, next_tpc, next_rv, next_ndi, next_harq, next_mcs} =
            grant_word[F1A_TAIL +: `DGFD_TAIL_LEN];
          next_access = grant_word[F1A_ACC +: `DGFD_ACCESS_W];
          next_mask = grant_word[F1A_MASK +: `DGFD_MASK_W];
        end
      end
      `DGFD_FMT_1:
      begin
        next_type1 = grant_word[0];
        next_ra = grant_word[1 +: RA_W];
        {next_dai, next_tpc, next_rv, next_ndi, next_harq, next_mcs} =
          grant_word[F1_TAIL +: `DGFD_TAIL_LEN];
      end
      `DGFD_FMT_1B, `DGFD_FMT_1D:
      begin
        next_dist = grant_word[0];
        next_ra = grant_word[1 +: RA_W];
        {next_dai, next_tpc, next_rv, next_ndi, next_harq, next_mcs} =
          grant_word[FB_TAIL +: `DGFD_TAIL_LEN];
        if (four_ports)
        begin
          next_granted_precoder_index = grant_word[FB_GRANTED_PRECODER_INDEX +: 4];
          tail = 5'h04;
        end
        else
        begin
          next_granted_precoder_index = {2'h0, grant_word[FB_GRANTED_PRECODER_INDEX +: 2]};
          tail = 5'h02;
        end
        if (fmt_sel == `DGFD_FMT_1B)
          next_confirm = grant_word[FB_GRANTED_PRECODER_INDEX + tail];
        else
          next_offset_bit = grant_word[FB_GRANTED_PRECODER_INDEX + tail];
      end
      `DGFD_FMT_1C:
      begin
        next_gap = grant_word[0];
        next_ra = grant_word[1 +: RA_W];
        next_tbs = grant_word[F1_TAIL +: `DGFD_TBS_W];
      end
      `DGFD_FMT_2:
      begin
        next_type1 = grant_word[0];
        next_ra = grant_word[1 +: RA_W];
        next_tpc = grant_word[F2_TPC +: `DGFD_TPC_W];
        next_dai = grant_word[F2_DAI +: `DGFD_DAI_W];
        next_harq = grant_word[F2_HARQ +: `DGFD_HARQ_W];
      end
      default:
        next_bad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // uplink slot and offset resolution
  // ----------------------------------------------------------------
  wire [4:0] x_first = ul_search(ul_mask, slot_n, 1'b0);
  wire [4:0] x_second = ul_search(ul_mask, slot_n, 1'b1);
  wire [2:0] k_val = k_lookup(ul_cfg, slot_n, next_ulsel == `DGFD_ULSEL_SECOND);
  wire [1:0] dai_expect = last_dai + 2'h1;
  wire has_dai = is_dl & ~next_bad & (fmt_sel != `DGFD_FMT_1C);

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_grant_valid <= 1'b0;
      o_format <= 3'h0;
      o_bad_grant <= 1'b0;
      o_resource_assignment <= {RA_W{1'b0}};
      o_alloc_type1 <= 1'b0;
      o_distributed <= 1'b0;
      o_gap <= 1'b0;
      o_mcs <= 5'h00;
      o_harq <= 4'h0;
      o_new_block <= 1'b0;
      o_rv <= 2'h0;
      o_ctrl_power_step <= 3'h0;
      o_assign_value <= 3'h0;
      o_missed_grants <= 2'h0;
      o_report_request <= 1'b0;
      o_granted_precoder_index <= 4'h0;
      o_use_granted_precoder <= 1'b0;
      o_power_offset_low <= 1'b0;
      o_access_seq <= 6'h00;
      o_mask_index <= 4'h0;
      o_tbs_index <= 5'h00;
      o_ul_first_valid <= 1'b0;
      o_ul_first_slot <= 4'h0;
      o_ul_second_valid <= 1'b0;
      o_ul_second_slot <= 4'h0;
      o_k_offset <= 3'h0;
      o_sched_valid <= 1'b0;
      o_sched_slot <= 4'h0;
      last_dai <= 2'h3;
      ndi_seen <= 16'h0000;
      harq_used <= 16'h0000;
    end
    else
    begin
      o_grant_valid <= decode_go;
      o_report_request <= 1'b0;
      if (ctrl[`DGFD_CTRL_WINCLR_BIT])
        last_dai <= 2'h3;
      if (decode_go)
      begin
        o_format <= next_format;
        o_bad_grant <= next_bad;
        o_resource_assignment <= next_ra;
        o_alloc_type1 <= next_type1;
        o_distributed <= next_dist;
        o_gap <= next_gap;
        o_mcs <= next_mcs;
        o_harq <= next_harq;
        o_rv <= next_rv;
        o_granted_precoder_index <= next_granted_precoder_index;
        o_use_granted_precoder <= next_confirm;
        o_power_offset_low <= (fmt_sel == `DGFD_FMT_1D) & ~next_offset_bit;
        o_access_seq <= next_access;
        o_mask_index <= next_mask;
        o_tbs_index <= next_tbs;
        o_assign_value <= {1'b0, next_dai} + 3'h1;
        o_report_request <= ~is_dl & next_cqi;
        case (next_tpc)
          2'h0:
            o_ctrl_power_step <= 3'h7;
          2'h1:
            o_ctrl_power_step <= 3'h0;
          2'h2:
            o_ctrl_power_step <= 3'h1;
          default:
            o_ctrl_power_step <= 3'h3;
        endcase
        // new-data toggle compared per process
        if (is_dl && !next_bad && fmt_sel != `DGFD_FMT_1C && fmt_sel != `DGFD_FMT_2)
        begin
          o_new_block <= ~harq_used[next_harq] | (ndi_seen[next_harq] ^ next_ndi);
          ndi_seen[next_harq] <= next_ndi;
          harq_used[next_harq] <= 1'b1;
        end
        else
          o_new_block <= 1'b0;
        // missed downlink grants from a gap in the running count
        if (has_dai && ul_cfg != 2'h0)
        begin
          o_missed_grants <= next_dai - dai_expect;
          last_dai <= next_dai;
        end
        else
          o_missed_grants <= 2'h0;
        // uplink scheduling only for a valid uplink grant
        if (!is_dl && !next_bad)
        begin
          o_ul_first_valid <= next_ulsel[1] & (x_first != 5'h00);
          o_ul_first_slot <= slot_add(slot_n, x_first);
          o_ul_second_valid <= next_ulsel[0] & (x_second != 5'h00);
          o_ul_second_slot <= slot_add(slot_n, x_second);
          o_k_offset <= k_val;
          o_sched_valid <= (k_val != 3'h0);
          o_sched_slot <= slot_add(slot_n, {2'h0, k_val});
        end
        else
        begin
          o_ul_first_valid <= 1'b0;
          o_ul_second_valid <= 1'b0;
          o_k_offset <= 3'h0;
          o_sched_valid <= 1'b0;
        end
      end
    end
  end

endmodule // dgfd_decoder

/* File: sim/dgfd_chk.sv */
`timescale 1ns/1ps
`include "dgfd_regs.vh"
module dgfd_chk (
  // clock and reset
  input wire i_sys_clk,
  input wire i_reset,
  // bus
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire o_wb_ack,
  // results
  input wire o_grant_valid,
  input wire [2:0] o_format,
  input wire o_bad_grant,
  input wire [4:0] o_mcs,
  input wire [3:0] o_harq,
  input wire [1:0] o_rv,
  input wire [2:0] o_ctrl_power_step,
  input wire [2:0] o_assign_value,
  input wire o_report_request,
  input wire o_ul_first_valid,
  input wire [3:0] o_ul_first_slot,
  input wire o_ul_second_valid,
  input wire [2:0] o_k_offset,
  input wire o_sched_valid
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  wire dec_req = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr == `DGFD_DECODE_OFS;
  wire ul_ok = o_grant_valid && o_format == 3'h0 && !o_bad_grant;
  wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer late or not a pulse");
  decode_answer_a: assert property (dec_req && o_wb_ack |->
    ##2 o_grant_valid ##1 !o_grant_valid)
    else $error("decode result pulse missing");
  results_hold_a: assert property (!o_grant_valid |-> $stable(o_mcs) && $stable(o_harq) && $stable(o_rv))
    else $error("results changed without a decode");
  report_pulse_a: assert property (o_report_request |-> o_grant_valid && o_format == 3'h0)
    else $error("report request outside an uplink grant");
  ul_reserved_a: assert property (o_grant_valid && o_format == 3'h0 && o_bad_grant |-> !o_ul_first_valid && !o_ul_second_valid && !o_sched_valid)
    else $error("reserved slot select scheduled a slot");
  assign_range_a: assert property (ul_ok |-> o_assign_value != 3'h0 && o_assign_value <= 3'h4)
    else $error("assignment value out of range");
  k_values_a: assert property (o_sched_valid |-> o_k_offset >= 3'h4 && o_format == 3'h0)
    else $error("offset k illegal");
  ul_slots_a: assert property (o_grant_valid && o_ul_first_valid |-> o_ul_first_slot < 4'hA)
    else $error("first uplink slot beyond frame");
  power_step_a: assert property (o_grant_valid |-> !(o_ctrl_power_step inside {3'h2, 3'h4, 3'h5, 3'h6}))
    else $error("power step code illegal");
  cov_ul_c: cover property (o_sched_valid && o_ul_second_valid);
  cov_bad_c: cover property (o_grant_valid && o_bad_grant);
  cov_dl_c: cover property (o_grant_valid && o_format == 3'h6);
endmodule // dgfd_chk
bind dgfd_decoder dgfd_chk u_chk (.*);

/* File: sim/dgfd_sched_model.sv */
`timescale 1ns/1ps
`include "dgfd_regs.vh"
module dgfd_sched_model (
  // clock
  input wire i_sys_clk,
  // bus master
  input wire i_wb_ack,
  input wire [31:0] i_wb_dat,
  output reg o_wb_cyc,
  output reg o_wb_stb,
  output reg o_wb_we,
  output reg [7:0] o_wb_adr,
  output reg [3:0] o_wb_sel,
  output reg [31:0] o_wb_dat
);
  initial
  begin
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we = 1'b0;
    o_wb_adr = 8'h00;
    o_wb_sel = 4'hF;
    o_wb_dat = 32'h0;
  end
  // ----------------------------------------
  // one classic cycle, held until ack
  // ----------------------------------------
  task xfer(input we, input [7:0] adr, input [31:0] wd, output [31:0] rd);
    integer n;
    begin
      @(posedge i_sys_clk);
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we <= we;
      o_wb_adr <= adr;
      o_wb_dat <= wd;
      n = 0;
      @(posedge i_sys_clk);
      while (i_wb_ack !== 1'b1 && n < 20)
      begin
        @(posedge i_sys_clk);
        n = n + 1;
      end
      rd = i_wb_dat;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_dat <= ~wd;
      if (n == 20)
      begin
        tb.failures = tb.failures + 1;
        tb.test_done;
      end
    end
  endtask
  // word low, high, control, then decode
  task grant(input [31:0] c, input [63:0] w);
    reg [31:0] d;
    begin
      xfer(1'b1, `DGFD_WORDLO_OFS, w[31:0], d);
      xfer(1'b1, `DGFD_WORDHI_OFS, w[63:32], d);
      xfer(1'b1, `DGFD_CTRL_OFS, c, d);
      xfer(1'b1, `DGFD_DECODE_OFS, 32'h0, d);
    end
  endtask
endmodule // dgfd_sched_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
`include "dgfd_regs.vh"
module tb;
  reg i_sys_clk;
  reg i_reset;
  wire i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_grant_valid, o_bad_grant, o_alloc_type1;
  wire o_distributed, o_gap, o_new_block, o_report_request, o_use_granted_precoder;
  wire o_power_offset_low, o_ul_first_valid, o_ul_second_valid, o_sched_valid;
  wire [7:0] i_wb_adr, o_resource_assignment;
  wire [3:0] i_wb_sel, o_harq, o_granted_precoder_index, o_mask_index;
  wire [3:0] o_ul_first_slot, o_ul_second_slot, o_sched_slot;
  wire [31:0] i_wb_dat, o_wb_dat;
  wire [2:0] o_format, o_ctrl_power_step, o_assign_value, o_k_offset;
  wire [4:0] o_mcs, o_tbs_index;
  wire [1:0] o_rv, o_missed_grants;
  wire [5:0] o_access_seq;
  integer failures, n_checks, i, k;
  reg [31:0] rd;
  reg [63:0] w;
  localparam [71:0] KT = 72'h116_144_234_307_395_054;
  localparam [11:0] PW = {3'h3, 3'h1, 3'h0, 3'h7};
  dgfd_decoder #(.RA_W(8)) dut (.*);
  dgfd_sched_model sched (.i_sys_clk(i_sys_clk), .i_wb_ack(o_wb_ack), .i_wb_dat(o_wb_dat),
    .o_wb_cyc(i_wb_cyc), .o_wb_stb(i_wb_stb), .o_wb_we(i_wb_we), .o_wb_adr(i_wb_adr),
    .o_wb_sel(i_wb_sel), .o_wb_dat(i_wb_dat));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task test_done;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task dec(input [31:0] c, input [63:0] wd);
    integer n;
    begin
      sched.grant(c, wd);
      n = 0;
      @(posedge i_sys_clk);
      #1;
      while (o_grant_valid !== 1'b1)
      begin
        n = n + 1;
        if (n > 4)
        begin
          failures = failures + 1;
          test_done;
        end
        @(posedge i_sys_clk);
        #1;
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      sched.xfer(1'b0, `DGFD_CTRL_OFS, 32'h0, rd);
      chk("ctrl", `DGFD_CTRL_RST, rd);
      sched.xfer(1'b0, `DGFD_ULMASK_OFS, 32'h0, rd);
      chk("ulmask", {22'h0, `DGFD_ULMASK_RST}, rd);
      sched.xfer(1'b1, 8'h40, 32'h1234_5678, rd);
      sched.xfer(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      sched.xfer(1'b1, `DGFD_CTRL_OFS, 32'hFFFF_0A51, rd);
      sched.xfer(1'b0, `DGFD_CTRL_OFS, 32'h0, rd);
      chk("ctrl_wr", 32'h0000_0A51, rd);
      sched.xfer(1'b0, `DGFD_DECODE_OFS, 32'h0, rd);
      chk("decode_rd", 32'h0, rd);
    end
  endtask
  task t_uplink;
    begin
      sched.xfer(1'b1, `DGFD_ULMASK_OFS, 32'h39C, rd);
      for (i = 0; i < 4; i = i + 1)
      begin
        dec(32'h0, {58'h0, i[0], i[1:0], i[1:0], 1'b0});
        chk("bad", i == 0, o_bad_grant);
        chk("first", i[1], o_ul_first_valid);
        chk("second", i[0], o_ul_second_valid);
        chk("sched", i != 0, o_sched_valid);
        chk("assign", i + 1, o_assign_value);
        chk("report", i[0], o_report_request);
        if (i[1])
          chk("first_slot", 4'h4, o_ul_first_slot);
        if (i[0])
          chk("second_slot", 4'h7, o_ul_second_slot);
        if (i != 0)
          chk("k", (i == 1) ? 7 : 4, o_k_offset);
      end
    end
  endtask
  task t_koff;
    begin
      for (i = 0; i < 6; i = i + 1)
      begin
        k = KT[i*12 +: 12];
        dec({20'h0, KT[i*12+4 +: 4], 6'h0, KT[i*12+8 +: 2]}, 64'h4);
        chk("k", k % 16, o_k_offset);
        chk("slot", ((k / 16) % 16 + k % 16) % 10, o_sched_slot);
      end
    end
  endtask
  task t_dl1;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        w = {39'h0, (i == 4) ? 2'h1 : i[1:0], i[1:0], i[1:0], i[1], 4'hF, 5'h1F ^ i[4:0],
          8'hA5 ^ i[7:0], i[0]};
        dec(32'h11, w);
        chk("type1", i[0], o_alloc_type1);
        chk("ra", 8'hA5 ^ i[7:0], o_resource_assignment);
        chk("mcs", 5'h1F ^ i[4:0], o_mcs);
        chk("harq", 4'hF, o_harq);
        chk("rv", i[1:0], o_rv);
        chk("power", PW[i[1:0]*3 +: 3], o_ctrl_power_step);
        chk("missed", i == 4, o_missed_grants);
        chk("new_block", !i[0], o_new_block);
      end
      dec(32'h19, 64'h0);
      chk("win_clr", 2'h0, o_missed_grants);
    end
  endtask
  task t_compact;
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        dec(32'h0, {28'h0, 4'hF, 6'h2A, 2'h0, 2'h3, 2'h2, 1'b1, 4'hA, 5'h0C, 8'h3C, i[0], 1'b1});
        chk("format", 3'h6, o_format);
        chk("dist", i[0], o_distributed);
        chk("access", 6'h2A, o_access_seq);
        chk("mask", 4'hF, o_mask_index);
        chk("mcs", 5'h0C, o_mcs);
        chk("harq", 4'hA, o_harq);
        chk("power", 3'h3, o_ctrl_power_step);
        chk("ra", 8'h3C, o_resource_assignment);
      end
    end
  endtask
  task t_prec;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        w = {39'h0, 16'h5A3C, 8'h77, 1'b1};
        if (i[1])
          w = w | (64'hB << 25) | (i[0] << 29);
        else
          w = w | (64'h2 << 25) | (i[0] << 27) | (!i[0] << 28);
        dec((i[2] ? 32'h40 : 32'h20) | (i[1] << 2), w);
        chk("format", i[2] ? 3'h4 : 3'h2, o_format);
        chk("granted_precoder_index", i[1] ? 4'hB : 4'h2, o_granted_precoder_index);
        if (i[2])
          chk("offset", !i[0], o_power_offset_low);
        else
          chk("confirm", i[0], o_use_granted_precoder);
      end
    end
  endtask
  task t_misc;
    begin
      dec(32'h30, {50'h0, 5'h15, 8'h81, 1'b1});
      chk("gap", 1'b1, o_gap);
      chk("tbs", 5'h15, o_tbs_index);
      chk("ra", 8'h81, o_resource_assignment);
      dec(32'h50, {47'h0, 4'h9, 2'h0, 2'h0, 8'h42, 1'b1});
      chk("harq", 4'h9, o_harq);
      chk("power", 3'h7, o_ctrl_power_step);
      chk("type1", 1'b1, o_alloc_type1);
      chk("ra", 8'h42, o_resource_assignment);
      dec(32'h70, 64'h0);
      chk("bad_sel", 1'b1, o_bad_grant);
      chk("format", 3'h7, o_format);
    end
  endtask
  initial
  begin
    failures = 0;
    n_checks = 0;
    i_reset = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_regs;
    t_uplink;
    t_koff;
    t_dl1;
    t_compact;
    t_prec;
    t_misc;
    test_done;
  end
endmodule // tb
